// ### rtl/sibsp_pkg.sv
// Purpose: Shared constants and types of the separate-port burst SRAM port.
// Assumes: Four-word double-rate bursts of 18-bit words, two 9-bit lanes.
// Notes:   Slot placement constants set the two read latencies.

package sibsp_pkg;
  localparam int WORD_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int BURST = 4;
  localparam int ADDR_W = 20;
  localparam int ARRAY_AW = 8;
  localparam int SYNC_STAGES = 2;
  // --------------------------------------------------------------------
  // Read slot placement in half cycles after the load edge
  // --------------------------------------------------------------------
  localparam int SLOT_N = 4;
  localparam int HALF_BASE_SHORT = 0;
  localparam int HALF_BASE_LONG = 3;
  localparam int BURST_W = BURST * WORD_W;
  localparam int BE_W = BURST * LANES;
  localparam logic RST_LOW = 1'b0;
  localparam logic RST_HIGH = 1'b1;

  typedef logic [WORD_W-1:0] sibsp_word_t;
  typedef logic [LANES-1:0] sibsp_lane_t;
  typedef logic [BURST_W-1:0] sibsp_burst_t;
  typedef logic [BE_W-1:0] sibsp_be_t;
  typedef enum logic {
    SIBSP_PH_RD = 1'b0,
    SIBSP_PH_WR = 1'b1
  } sibsp_phase_t;
endpackage

// ### rtl/sibsp_evt_sync.sv
// Purpose: Carries a toggle event from the K domain into the clk domain.
// Assumes: Events at least three clk cycles apart.
// Notes:   Output pulse is one clk cycle, registered.
`timescale 1ns/1ps

module sibsp_evt_sync (
  input wire logic clk,      // System clock
  input wire logic srst,     // Synchronous reset, active high
  input wire logic ce,       // Clock enable, freezes state when low
  input wire logic tgl_in,   // Toggle from the far domain
  output logic pulse         // One-cycle pulse per toggle
);
  import sibsp_pkg::*;

  logic meta;
  logic sync;
  logic last;
  logic next_pulse;

  always_comb begin
    next_pulse = sync ^ last;
  end

  // Meta stage feeds only the sync stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= RST_LOW;
      sync <= RST_LOW;
      last <= RST_LOW;
      pulse <= RST_LOW;
    end else if (ce) begin
      meta <= tgl_in;
      sync <= meta;
      last <= sync;
      pulse <= next_pulse;
    end
  end

  a_evt_pulse_out: assert property (
    @(posedge clk) disable iff (srst)
    (ce && $changed(sync)) |=> pulse)
    else $error("toggle did not yield a pulse");

endmodule // sibsp_evt_sync

// ### rtl/sibsp_core.sv
// Purpose: Device side of a separate-port four-word double-rate SRAM.
// Assumes: K and K# same rate, K# rising half a period after K rising.
// Notes:   Array keeps 2**ARRAY_AW bursts; upper address bits alias.
`timescale 1ns/1ps

module sibsp_core #(
  parameter int ADDR_W = sibsp_pkg::ADDR_W,
  parameter int ARRAY_AW = sibsp_pkg::ARRAY_AW
) (
  input wire logic clk,                            // System clock
  input wire logic srst,                           // Sync reset, active high
  input wire logic ce,                             // Clock enable, clk domain
  input wire logic k_clk,                          // Reference clock K
  input wire logic k_n_clk,                        // Reference clock K#
  input wire logic pll_bypass_n,                   // High: 2.5 cycle latency
  input wire logic [ADDR_W-1:0] addr,              // Shared address bus
  input wire logic read_port_sel_n,                // Read select, low active
  input wire logic write_port_sel_n,               // Write select, low active
  input wire sibsp_pkg::sibsp_word_t d,            // Write data
  input wire sibsp_pkg::sibsp_lane_t byte_lane_enable_n, // Lane enables
  output sibsp_pkg::sibsp_word_t q_k_data,         // Word launched on K
  output sibsp_pkg::sibsp_word_t q_kn_data,        // Word launched on K#
  output logic q_oe,                               // Read outputs driven
  output logic output_valid_flag_k,                // q_k_data valid
  output logic output_valid_flag_kn,               // q_kn_data valid
  output logic echo_strobe,                        // Echo, toggles on K
  output logic echo_strobe_n,                      // Echo, toggles on K#
  output logic addr_slot_is_read,                  // Next K edge takes read
  output logic rd_done,                            // Read taken, clk pulse
  output logic wr_done                             // Write done, clk pulse
);
  import sibsp_pkg::*;

  // --------------------------------------------------------------------
  // Reset and mode into the K domain
  // --------------------------------------------------------------------
  logic rst_meta;
  logic rst_k;
  logic mode_meta;
  logic lat_long;

  always_ff @(posedge k_clk) begin
    rst_meta <= srst;
    rst_k <= rst_meta;
    mode_meta <= pll_bypass_n;
    lat_long <= mode_meta;
  end

  // --------------------------------------------------------------------
  // Input registers
  // --------------------------------------------------------------------
  sibsp_phase_t phase;
  sibsp_phase_t next_phase;
  logic in_is_rd;
  logic [ADDR_W-1:0] in_addr;
  logic in_rps_n;
  logic in_wps_n;
  sibsp_word_t in_d_k;
  sibsp_lane_t in_be_k;
  sibsp_word_t in_d_kn;
  sibsp_lane_t in_be_kn;

  always_comb begin
    next_phase = (phase == SIBSP_PH_RD) ? SIBSP_PH_WR : SIBSP_PH_RD;
  end

  // Only rising edges; K# data halves are caught on their own clock
  always_ff @(posedge k_clk) begin
    in_addr <= addr;
    in_d_k <= d;
    in_be_k <= byte_lane_enable_n;
    if (rst_k) begin
      phase <= SIBSP_PH_RD;
      in_is_rd <= RST_LOW;
      in_rps_n <= RST_HIGH;
      in_wps_n <= RST_HIGH;
    end else begin
      phase <= next_phase;
      in_is_rd <= (phase == SIBSP_PH_RD);
      in_rps_n <= read_port_sel_n;
      in_wps_n <= write_port_sel_n;
    end
  end

  always_ff @(posedge k_n_clk) begin
    in_d_kn <= d;
    in_be_kn <= byte_lane_enable_n;
  end

  // --------------------------------------------------------------------
  // Write assembly and self-timed commit
  // --------------------------------------------------------------------
  function automatic sibsp_burst_t merge_burst(input sibsp_burst_t old_b,
                                               input sibsp_burst_t new_b,
                                               input sibsp_be_t be_n);
    sibsp_burst_t r;
    r = old_b;
    for (int i = 0; i < BE_W; i++) begin
      if (!be_n[i]) begin
        r[i*LANE_W +: LANE_W] = new_b[i*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction

  logic wr_take;
  logic asm_vld;
  logic next_asm_vld;
  logic [ARRAY_AW-1:0] asm_idx;
  sibsp_word_t asm_w0;
  sibsp_word_t asm_w1;
  sibsp_lane_t asm_be0;
  sibsp_lane_t asm_be1;
  logic com_valid;
  logic [ARRAY_AW-1:0] com_idx;
  sibsp_burst_t com_data;
  sibsp_be_t com_be_n;
  sibsp_burst_t mem [2**ARRAY_AW];
  sibsp_burst_t next_mem_word;
  logic wr_tgl;
  logic next_wr_tgl;

  always_comb begin
    wr_take = !in_is_rd && !in_wps_n;
    next_asm_vld = wr_take;
    com_valid = asm_vld;
    com_idx = asm_idx;
    com_data = {in_d_kn, in_d_k, asm_w1, asm_w0};
    com_be_n = {in_be_kn, in_be_k, asm_be1, asm_be0};
    next_mem_word = merge_burst(mem[com_idx], com_data, com_be_n);
    next_wr_tgl = wr_tgl ^ com_valid;
  end

  always_ff @(posedge k_clk) begin
    asm_idx <= in_addr[ARRAY_AW-1:0];
    asm_w0 <= in_d_k;
    asm_w1 <= in_d_kn;
    asm_be0 <= in_be_k;
    asm_be1 <= in_be_kn;
    if (rst_k) begin
      asm_vld <= RST_LOW;
      wr_tgl <= RST_LOW;
    end else begin
      asm_vld <= next_asm_vld;
      wr_tgl <= next_wr_tgl;
    end
  end

  // No write pulse from outside: commit rides the K edge after word three
  always_ff @(posedge k_clk) begin
    if (com_valid) begin
      mem[com_idx] <= next_mem_word;
    end
  end

  // --------------------------------------------------------------------
  // Read load, forwarding and half-cycle slot line
  // --------------------------------------------------------------------
  logic rd_load;
  logic [ARRAY_AW-1:0] rd_idx;
  sibsp_burst_t rd_data;
  logic st_k_vld [SLOT_N-1];
  logic st_n_vld [SLOT_N-1];
  sibsp_word_t st_k_dat [SLOT_N-1];
  sibsp_word_t st_n_dat [SLOT_N-1];
  logic pk_vld [SLOT_N];
  logic pn_vld [SLOT_N];
  sibsp_word_t pk_dat [SLOT_N];
  sibsp_word_t pn_dat [SLOT_N];
  sibsp_word_t kn_stage;
  logic kn_stage_vld;
  logic next_q_oe;
  logic slots_busy;
  logic rd_tgl;
  logic next_rd_tgl;

  always_comb begin
    int h;
    int base;
    h = 0;
    base = lat_long ? HALF_BASE_LONG : HALF_BASE_SHORT;
    rd_load = in_is_rd && !in_rps_n;
    rd_idx = in_addr[ARRAY_AW-1:0];
    // A write committing on this edge is newer than the array copy
    rd_data = (com_valid && com_idx == rd_idx) ? next_mem_word
                                               : mem[rd_idx];
    for (int i = 0; i < SLOT_N; i++) begin
      if (i < SLOT_N - 1) begin
        pk_vld[i] = st_k_vld[i];
        pn_vld[i] = st_n_vld[i];
        pk_dat[i] = st_k_dat[i];
        pn_dat[i] = st_n_dat[i];
      end else begin
        pk_vld[i] = RST_LOW;
        pn_vld[i] = RST_LOW;
        pk_dat[i] = '0;
        pn_dat[i] = '0;
      end
    end
    // Reads two cycles apart in one latency mode never land on the same half slot
    if (rd_load) begin
      for (int i = 0; i < BURST; i++) begin
        h = base + i;
        if (h % 2 == 0) begin
          pk_vld[h/2] = RST_HIGH;
          pk_dat[h/2] = rd_data[i*WORD_W +: WORD_W];
        end else begin
          pn_vld[h/2] = RST_HIGH;
          pn_dat[h/2] = rd_data[i*WORD_W +: WORD_W];
        end
      end
    end
    slots_busy = RST_LOW;
    for (int i = 0; i < SLOT_N; i++) begin
      slots_busy = slots_busy | pk_vld[i] | pn_vld[i];
    end
    next_q_oe = slots_busy;
    next_rd_tgl = rd_tgl ^ rd_load;
  end

  always_ff @(posedge k_clk) begin
    q_k_data <= pk_dat[0];
    kn_stage <= pn_dat[0];
    for (int i = 0; i < SLOT_N - 1; i++) begin
      st_k_dat[i] <= pk_dat[i+1];
      st_n_dat[i] <= pn_dat[i+1];
    end
    if (rst_k) begin
      output_valid_flag_k <= RST_LOW;
      kn_stage_vld <= RST_LOW;
      q_oe <= RST_LOW;
      echo_strobe <= RST_LOW;
      rd_tgl <= RST_LOW;
      addr_slot_is_read <= RST_LOW;
      for (int i = 0; i < SLOT_N - 1; i++) begin
        st_k_vld[i] <= RST_LOW;
        st_n_vld[i] <= RST_LOW;
      end
    end else begin
      output_valid_flag_k <= pk_vld[0];
      kn_stage_vld <= pn_vld[0];
      q_oe <= next_q_oe;
      echo_strobe <= !echo_strobe;
      rd_tgl <= next_rd_tgl;
      addr_slot_is_read <= (next_phase == SIBSP_PH_RD);
      for (int i = 0; i < SLOT_N - 1; i++) begin
        st_k_vld[i] <= pk_vld[i+1];
        st_n_vld[i] <= pn_vld[i+1];
      end
    end
  end

  // K# launch takes the word staged half a period earlier on K
  always_ff @(posedge k_n_clk) begin
    q_kn_data <= kn_stage;
    if (rst_k) begin
      output_valid_flag_kn <= RST_LOW;
      echo_strobe_n <= RST_HIGH;
    end else begin
      output_valid_flag_kn <= kn_stage_vld;
      echo_strobe_n <= !echo_strobe_n;
    end
  end

  // --------------------------------------------------------------------
  // Events into the clk domain
  // --------------------------------------------------------------------
  sibsp_evt_sync u_rd_evt (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .tgl_in(rd_tgl),
    .pulse(rd_done)
  );

  sibsp_evt_sync u_wr_evt (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .tgl_in(wr_tgl),
    .pulse(wr_done)
  );

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic [ARRAY_AW-1:0] chk_idx;
  logic [LANE_W-1:0] chk_old;

  always_ff @(posedge k_clk) begin
    chk_idx <= com_idx;
    chk_old <= mem[com_idx][LANE_W-1:0];
  end

  a_phase_alternates: assert property (
    @(posedge k_clk) disable iff (rst_k)
    in_is_rd |=> !in_is_rd)
    else $error("address slots did not alternate");

  a_short_lat_data: assert property (
    @(posedge k_clk) disable iff (rst_k)
    (rd_load && !lat_long) |=> (output_valid_flag_k && q_oe))
    else $error("short latency read word missing");

  // First long-mode word is staged on K one edge after the load edge, seen at the second check
  a_long_lat_data: assert property (
    @(posedge k_clk) disable iff (rst_k)
    (rd_load && lat_long) |-> ##2 kn_stage_vld ##1 output_valid_flag_k
      ##1 output_valid_flag_k)
    else $error("long latency read words misplaced");

  a_burst_halves: assert property (
    @(posedge k_clk) disable iff (rst_k)
    (rd_load && !lat_long) |=> kn_stage_vld
      ##1 (output_valid_flag_k && kn_stage_vld))
    else $error("burst words not on both edges");

  // Commit edge follows the take edge; the slot after is a read slot
  a_write_commit: assert property (
    @(posedge k_clk) disable iff (rst_k)
    wr_take |=> com_valid ##1 !com_valid)
    else $error("write not committed two edges later");

  a_echo_runs: assert property (
    @(posedge k_clk) disable iff (rst_k)
    $rose(echo_strobe) |=> $fell(echo_strobe))
    else $error("echo strobe stopped");

  a_fwd_pending: assert property (
    @(posedge k_clk) disable iff (rst_k)
    (rd_load && !lat_long && com_valid && com_idx == rd_idx
      && com_be_n[1:0] == '0) |=> (q_k_data == $past(asm_w0)))
    else $error("pending write not forwarded");

  a_lane_kept: assert property (
    @(posedge k_clk) disable iff (rst_k)
    (com_valid && com_be_n[0]) |=> (mem[chk_idx][LANE_W-1:0] == chk_old))
    else $error("disabled lane was written");

  a_oe_release: assert property (
    @(posedge k_clk) disable iff (rst_k)
    (!rd_load && !output_valid_flag_k && !kn_stage_vld && !slots_busy)
      |=> !q_oe)
    else $error("read outputs not released");

endmodule // sibsp_core

// ### verif/sibsp_ctrl_model.sv
// Purpose: Controller model driving the K-domain request side.
// Assumes: Slot phase read from addr_slot_is_read after each K rise.
// Notes:   Released address and data lines invert, so stale values never pass as data.
`timescale 1ns/1ps

module sibsp_ctrl_model (
  input wire logic k_clk, // Reference clock K
  input wire logic k_n_clk, // Reference clock K#
  input wire logic addr_slot_is_read, // Coming K rise is a read slot
  input wire sibsp_pkg::sibsp_word_t q_k_data, // Word launched on K
  input wire sibsp_pkg::sibsp_word_t q_kn_data, // Word launched on K#
  input wire logic output_valid_flag_k, // K word valid
  input wire logic output_valid_flag_kn, // K# word valid
  output logic [sibsp_pkg::ADDR_W-1:0] addr, // Shared address
  output logic read_port_sel_n, // Read select
  output logic write_port_sel_n, // Write select
  output sibsp_pkg::sibsp_word_t d, // Write data
  output sibsp_pkg::sibsp_lane_t byte_lane_enable_n // Lane enables
);
  import sibsp_pkg::*;
  logic own_ra = 1'b0;
  logic own_wa = 1'b0;
  logic own_d = 1'b0;

  initial begin
    addr = '0;
    read_port_sel_n = 1'b1;
    write_port_sel_n = 1'b1;
    d = '0;
    byte_lane_enable_n = 2'h3;
  end

  // ----
  // Idle scrambling
  // ----
  always @(posedge k_clk) begin
    #0.5;
    if (!own_ra && !own_wa) addr = ~addr;
  end
  always @(posedge k_clk or posedge k_n_clk) begin
    #0.5;
    if (!own_d) d = ~d;
  end

  task automatic wait_slot(input logic rd);
    @(posedge k_clk);
    #1;
    while (addr_slot_is_read !== rd) begin
      @(posedge k_clk);
      #1;
    end
  endtask

  // Whole burst per call puts the next request three cycles later for a read, four for a write
  task automatic write_burst(input logic [ADDR_W-1:0] a, input logic sel_n,
      input sibsp_burst_t b, input sibsp_be_t be_n);
    wait_slot(1'b0);
    own_wa = 1'b1;
    own_d = 1'b1;
    addr = a;
    write_port_sel_n = sel_n;
    for (int i = 0; i < BURST; i++) begin
      d = b[i*WORD_W +: WORD_W];
      byte_lane_enable_n = be_n[i*LANES +: LANES];
      if (i % 2 == 0) @(posedge k_clk);
      else @(posedge k_n_clk);
      #1;
      write_port_sel_n = 1'b1;
      own_wa = 1'b0;
    end
    own_d = 1'b0;
    byte_lane_enable_n = 2'h3;
  endtask

  // Gathers valid words over ten half cycles after the request edge
  task automatic read_burst(input logic [ADDR_W-1:0] a, input logic slot,
      input logic after_wr, output sibsp_burst_t b, output int first,
      output int cnt);
    first = -1;
    cnt = 0;
    b = '0;
    if (after_wr) wait (own_wa);
    wait_slot(slot);
    own_ra = 1'b1;
    addr = a;
    read_port_sel_n = 1'b0;
    @(posedge k_clk);
    #1;
    read_port_sel_n = 1'b1;
    own_ra = 1'b0;
    for (int h = 1; h <= 10; h++) begin
      if (h % 2) @(posedge k_n_clk);
      else @(posedge k_clk);
      #1;
      if (h % 2 ? output_valid_flag_kn : output_valid_flag_k) begin
        if (first < 0) first = h;
        if (cnt < BURST)
          b[cnt*WORD_W +: WORD_W] = h % 2 ? q_kn_data : q_k_data;
        cnt++;
      end
    end
  endtask
endmodule // sibsp_ctrl_model

// ### verif/tb.sv
// Purpose: Self-checking bench for the separate-port burst SRAM port.
// Assumes: Controller model drives every K-domain request input.
// Notes:   K runs at 12 ns, unrelated in phase to clk.
`timescale 1ns/1ps

module tb;
  import sibsp_pkg::*;
  localparam sibsp_burst_t DA = 72'h123456789abcdef012;
  localparam sibsp_burst_t DB = 72'hfedcba9876543210ed;
  localparam sibsp_burst_t DC = 72'h0f1e2d3c4b5a697887;
  logic clk = 1'b0;
  logic k_clk = 1'b0;
  wire logic k_n_clk;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic pll_bypass_n = 1'b0;
  wire logic [ADDR_W-1:0] addr;
  wire logic read_port_sel_n;
  wire logic write_port_sel_n;
  wire sibsp_word_t d;
  wire sibsp_lane_t byte_lane_enable_n;
  wire sibsp_word_t q_k_data;
  wire sibsp_word_t q_kn_data;
  wire logic q_oe;
  wire logic output_valid_flag_k;
  wire logic output_valid_flag_kn;
  wire logic echo_strobe;
  wire logic echo_strobe_n;
  wire logic addr_slot_is_read;
  wire logic rd_done;
  wire logic wr_done;
  int errors = 0;
  int total_checks = 0;
  int rd_cnt = 0;
  int wr_cnt = 0;
  sibsp_burst_t got;
  int first;
  int cnt;

  assign k_n_clk = ~k_clk;
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    #3.7;
    forever #6 k_clk = ~k_clk;
  end
  always @(negedge clk) begin
    if (rd_done === 1'b1) rd_cnt++;
    if (wr_done === 1'b1) wr_cnt++;
  end

  sibsp_core u_dut (.clk, .srst, .ce, .k_clk, .k_n_clk, .pll_bypass_n,
    .addr, .read_port_sel_n, .write_port_sel_n, .d, .byte_lane_enable_n,
    .q_k_data, .q_kn_data, .q_oe, .output_valid_flag_k,
    .output_valid_flag_kn, .echo_strobe, .echo_strobe_n,
    .addr_slot_is_read, .rd_done, .wr_done);
  sibsp_ctrl_model u_ctrl (.k_clk, .k_n_clk, .addr_slot_is_read,
    .q_k_data, .q_kn_data, .output_valid_flag_k, .output_valid_flag_kn,
    .addr, .read_port_sel_n, .write_port_sel_n, .d, .byte_lane_enable_n);

  // ----
  // Compare helpers
  // ----
  task automatic chk_w(input sibsp_word_t g, input sibsp_word_t e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_n(input int g, input int e);
    total_checks++;
    if (g != e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_burst(input sibsp_burst_t g, input sibsp_burst_t e);
    for (int i = 0; i < BURST; i++)
      chk_w(g[i*WORD_W +: WORD_W], e[i*WORD_W +: WORD_W]);
  endtask
  function automatic sibsp_burst_t merge(input sibsp_burst_t o,
      input sibsp_burst_t n, input sibsp_be_t be_n);
    merge = o;
    for (int i = 0; i < BE_W; i++)
      if (!be_n[i]) merge[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
  endfunction

  // ----
  // Scenarios
  // ----
  task automatic t_echo();
    logic s;
    logic sn;
    @(posedge k_clk);
    #1;
    s = echo_strobe;
    sn = echo_strobe_n;
    @(negedge k_clk);
    #1;
    chk_b(echo_strobe, s);
    chk_b(echo_strobe_n, ~sn);
    @(posedge k_clk);
    #1;
    chk_b(echo_strobe, ~s);
    $display("test echo done");
  endtask
  task automatic t_short();
    int w0;
    int r0;
    w0 = wr_cnt;
    r0 = rd_cnt;
    u_ctrl.write_burst(20'h00011, 1'b0, DA, '0);
    u_ctrl.read_burst(20'h00011, 1'b1, 1'b0, got, first, cnt);
    chk_n(first, 2);
    chk_n(cnt, BURST);
    chk_burst(got, DA);
    chk_b(q_oe, 1'b0);
    repeat (8) @(posedge clk);
    chk_n(wr_cnt - w0, 1);
    chk_n(rd_cnt - r0, 1);
    $display("test short read done");
  endtask
  task automatic t_lanes();
    u_ctrl.write_burst(20'h00022, 1'b0, DA, '0);
    u_ctrl.write_burst(20'h00022, 1'b0, DB, 8'h69);
    u_ctrl.write_burst(20'h00022, 1'b1, DC, '0);
    u_ctrl.read_burst(20'h00022, 1'b1, 1'b0, got, first, cnt);
    chk_burst(got, merge(DA, DB, 8'h69));
    $display("test lanes done");
  endtask
  task automatic t_coherent();
    u_ctrl.write_burst(20'h00033, 1'b0, DA, '0);
    fork
      u_ctrl.write_burst(20'h00033, 1'b0, DC, 8'hf0);
      u_ctrl.read_burst(20'h00033, 1'b1, 1'b1, got, first, cnt);
    join
    chk_burst(got, merge(DA, DC, 8'hf0));
    chk_n(first, 2);
    $display("test coherency done");
  endtask
  task automatic t_refuse();
    u_ctrl.read_burst(20'h00011, 1'b0, 1'b0, got, first, cnt);
    chk_n(cnt, 0);
    $display("test refused read done");
  endtask
  task automatic t_long();
    @(posedge clk);
    pll_bypass_n <= 1'b1;
    repeat (10) @(posedge clk);
    u_ctrl.read_burst(20'h00011, 1'b1, 1'b0, got, first, cnt);
    chk_n(first, 5);
    chk_n(cnt, BURST);
    chk_burst(got, DA);
    chk_b(q_oe, 1'b0);
    @(posedge clk);
    pll_bypass_n <= 1'b0;
    repeat (10) @(posedge clk);
    $display("test long read done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (40) begin
      @(posedge k_clk);
      if (addr_slot_is_read === 1'b1) break;
    end
    chk_b(addr_slot_is_read, 1'b1);
    t_echo();
    t_short();
    t_lanes();
    t_coherent();
    t_refuse();
    t_long();
    report_and_stop();
  end
  // Tests need a few microseconds; far margin before cutting a hang
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
endmodule // tb
